// File: verification/ltc_host_model.sv
// Purpose: two-wire bus master standing in for the host processor
// Assumes: pull-up on sda, so a released line reads high
// Notes: PH sets each scl phase in clk cycles; raise it for a slow host
`timescale 1ns/1ps
`default_nettype none
module ltc_host_model #(parameter int PH = 5) (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	// sda only moves while scl is low, so no false start or stop
	task automatic bit_io(input logic b, output logic s);
		wt(1);
		sda <= b;
		wt(PH);
		scl <= 1'b1;
		wt(3);
		s = sda_line;
		wt(PH - 3);
		scl <= 1'b0;
	endtask : bit_io
	task automatic start();
		wt(1);
		sda <= 1'b1;
		wt(PH);
		scl <= 1'b1;
		wt(PH);
		sda <= 1'b0;
		wt(PH);
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		wt(1);
		sda <= 1'b0;
		wt(PH);
		scl <= 1'b1;
		wt(PH);
		sda <= 1'b1;
		wt(PH);
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ai, a);
	endtask : xfer
	// ak returns the address acknowledge, low when a device answered
	task automatic wr(input logic [6:0] adr, input logic [7:0] p, input logic [7:0] v,
		output logic ak);
		logic [7:0] q;
		logic a;
		start();
		xfer({adr, 1'b0}, 1'b1, q, ak);
		xfer(p, 1'b1, q, a);
		xfer(v, 1'b1, q, a);
		stop();
	endtask : wr
	// consecutive registers in one burst, so related results stay together
	task automatic rd(input logic [7:0] p, input int n, output logic [23:0] d);
		logic [7:0] q;
		logic a;
		d = 24'h000000;
		start();
		xfer(8'h54, 1'b1, q, a);
		xfer(p, 1'b1, q, a);
		start();
		xfer(8'h55, 1'b1, q, a);
		for (int i = 0; i < n; i++) begin
			xfer(8'hFF, i == n - 1, q, a);
			d = {d[15:0], q};
		end
		stop();
	endtask : rd
endmodule : ltc_host_model
`default_nettype wire

// File: verification/tb_led_slot_and_die_temp_control.sv
// Purpose: self-checking bench for the led slot and die temperature block
// Assumes: device address 7'h2A, arbitrary; analog side modelled here
// Notes: random stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_led_slot_and_die_temp_control;
	localparam logic [6:0] ADR = 7'h2A;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sample_tick = 1'b0, slot_conv_done = 1'b0, temp_conv_done = 1'b0, fifo_ready = 1'b0;
	logic stall = 1'b0;
	logic [17:0] slot_result = 18'h00000, rv;
	logic [7:0] temp_whole_in = 8'h00;
	logic [3:0] temp_frac_in = 4'h0;
	logic scl, sda_h, sda_out, sda_oe, fifo_valid, led_red_on, led_ir_on;
	logic slot_conv_start, temp_conv_start;
	logic [23:0] fifo_word;
	logic [7:0] led_drive_code;
	logic [1:0] pulse_width_sel;
	logic [2:0] sample_rate_sel, mode_sel;
	logic [4:0] adc_res_bits;
	wire logic sda_w = sda_h & ~sda_oe;
	int fail_count, checked, cyc, tcnt, scnt, n_temp, n_start, n_words;
	logic [9:0] exp_q[$];
	logic [17:0] res_q[$];
	logic [7:0] regs[8] = '{8'h0C, 8'h0D, 8'h11, 8'h12, 8'h1F, 8'h20, 8'h30, 8'h21};
	logic [7:0] msk[7] = '{8'hFF, 8'hFF, 8'h77, 8'h77, 8'h00, 8'h00, 8'h00};
	logic [2:0] mds[5] = '{3'h7, 3'h7, 3'h3, 3'h2, 3'h0};

	ltc_top #(.DEV_ADDR(ADR)) i_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .sample_tick(sample_tick),
		.slot_conv_done(slot_conv_done), .slot_result(slot_result),
		.temp_conv_done(temp_conv_done), .temp_whole_in(temp_whole_in),
		.temp_frac_in(temp_frac_in), .fifo_ready(fifo_ready), .fifo_valid(fifo_valid),
		.fifo_word(fifo_word), .led_red_on(led_red_on), .led_ir_on(led_ir_on),
		.led_drive_code(led_drive_code), .slot_conv_start(slot_conv_start),
		.temp_conv_start(temp_conv_start), .pulse_width_sel(pulse_width_sel),
		.sample_rate_sel(sample_rate_sel), .adc_res_bits(adc_res_bits), .mode_sel(mode_sel));
	ltc_host_model i_host (.clk(clk), .sda_line(sda_w), .scl(scl), .sda(sda_h));

	always #5 clk = ~clk;

	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	// requested rate code capped at the highest that the mode and pulse width allow
	function automatic logic [2:0] clamp(input logic [2:0] md, input logic [1:0] pw,
		input logic [2:0] sr);
		logic [2:0] mx;
		mx = md == 3'h2 ? (pw == 2'h0 ? 3'h7 : pw == 2'h3 ? 3'h5 : 3'h6) : 3'h6 - 3'(pw);
		return sr > mx ? mx : sr;
	endfunction : clamp

	// queues {red, ir, code} per active slot and returns the slot count
	function automatic int plan(input logic [2:0] md, input logic [15:0] sl,
		input logic [7:0] ra, input logic [7:0] ia);
		logic [2:0] s;
		int n;
		n = 0;
		for (int i = 0; i < 4; i++) begin
			s = md == 3'h7 ? sl[4*i +: 3] : (md == 3'h3 && i < 2) ? 3'(i + 1) :
				(md == 3'h2 && i == 0) ? 3'h1 : 3'h0;
			if (s >= 3'h1 && s <= 3'h4) begin
				exp_q.push_back({s == 3'h1, s == 3'h2, s == 3'h1 ? ra : s == 3'h2 ? ia : 8'h00});
				n++;
			end
		end
		return n;
	endfunction : plan

	// analog side, fifo sink and hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			fail_count++;
			report_and_stop();
		end
		temp_conv_done <= tcnt == 1;
		tcnt <= temp_conv_start ? 1500 : (tcnt > 0 ? tcnt - 1 : 0);
		n_temp <= n_temp + int'(temp_conv_start);
		slot_conv_done <= scnt == 1;
		if (slot_conv_start) begin
			rv = 18'($urandom);
			slot_result <= rv;
			res_q.push_back(rv);
			scnt <= 3 + $urandom_range(12);
			n_start <= n_start + 1;
		end else begin
			scnt <= scnt > 0 ? scnt - 1 : 0;
		end
		if (slot_conv_done)
			check("slot leds and code", {led_red_on, led_ir_on, led_drive_code}, exp_q.pop_front());
		fifo_ready <= !stall && $urandom_range(3) != 0;
		if (fifo_valid && fifo_ready) begin
			n_words <= n_words + 1;
			check("fifo word", fifo_word, {6'h00, res_q.pop_front()});
		end
	end

	initial begin
		logic [23:0] d;
		logic [15:0] sl;
		logic [7:0] ra, ia, v;
		logic [2:0] md;
		logic ak;
		int n, base, bs;
		void'($urandom(2442));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (regs[i]) begin
			i_host.rd(regs[i], 1, d);
			check("reset value", d, 24'h000000);
		end
		for (int i = 0; i < 7; i++) begin
			v = 8'($urandom);
			ra = i == 0 ? v : ra;
			ia = i == 1 ? v : ia;
			i_host.wr(ADR, regs[i], v, ak);
			i_host.rd(regs[i], 1, d);
			check("readback", d, {16'h0000, v & msk[i]});
		end
		i_host.wr(7'h15, 8'h0C, ~ra, ak);
		check("foreign address ack", {23'h0, ak}, 24'h000001);
		i_host.rd(8'h0C, 2, d);
		check("drive codes", d, {8'h00, ra, ia});
		for (int k = 0; k < 2; k++) begin
			temp_whole_in <= k ? 8'($urandom) : 8'h80;
			temp_frac_in <= k ? 4'($urandom) : 4'h8;
			base = n_temp;
			i_host.wr(ADR, 8'h21, 8'h01, ak);
			i_host.rd(8'h21, 1, d);
			check("start bit busy", d, 24'h000001);
			// a second start while busy is absorbed
			i_host.wr(ADR, 8'h21, 8'h01, ak);
			repeat (1500) @(posedge clk);
			i_host.rd(8'h1F, 3, d);
			check("temp result", d, {temp_whole_in, 4'h0, temp_frac_in, 8'h00});
			check("conversions", 24'(n_temp - base), 24'h000001);
		end
		for (int m = 0; m < 2; m++) begin
			md = m ? 3'h3 : 3'h2;
			i_host.wr(ADR, 8'h09, {5'h00, md}, ak);
			for (int c = 0; c < 32; c++) begin
				i_host.wr(ADR, 8'h0A, 8'(c), ak);
				check("rate", {21'h0, sample_rate_sel}, {21'h0, clamp(md, c[1:0], c[4:2])});
				check("width", {17'h0, adc_res_bits, pulse_width_sel}, {17'h0, 5'(15 + c[1:0]), c[1:0]});
			end
		end
		for (int t = 0; t < 10; t++) begin
			md = mds[t % 5];
			n = t ? $urandom_range(4) : 4;
			// slots filled from slot one upward, then one reserved code if a slot is left
			for (int i = 0; i < 4; i++)
				sl[4*i +: 4] = i < n ? 4'($urandom_range(4, 1)) : i == n ? 4'($urandom_range(7, 5)) : 4'h0;
			i_host.wr(ADR, 8'h09, {5'h00, md}, ak);
			check("mode", {21'h0, mode_sel}, {21'h0, md});
			i_host.wr(ADR, 8'h11, sl[7:0], ak);
			i_host.wr(ADR, 8'h12, sl[15:8], ak);
			n = plan(md, sl, ra, ia);
			base = n_words;
			bs = n_start;
			stall <= t == 0;
			sample_tick <= 1'b1;
			@(posedge clk);
			sample_tick <= 1'b0;
			repeat (2) @(posedge clk);
			// this tick lands mid walk and must start nothing
			sample_tick <= 1'b1;
			@(posedge clk);
			sample_tick <= 1'b0;
			if (t == 0) begin
				repeat (100) @(posedge clk);
				check("starts while stalled", 24'(n_start - bs), 24'h000003);
				check("words while stalled", 24'(n_words - base), 24'h000000);
				stall <= 1'b0;
			end
			repeat (150) @(posedge clk);
			check("words per sample", 24'(n_words - base), 24'(n));
			check("slots left", 24'(exp_q.size()), 24'h000000);
		end
		report_and_stop();
	end
endmodule : tb_led_slot_and_die_temp_control
`default_nettype wire

// File: verilog/ltc_map.svh
// Purpose: register offsets, reset values and codes
// Assumes: byte-wide registers behind a serial register port
// Notes: included by bare name
`ifndef LTC_MAP_SVH
`define LTC_MAP_SVH
`define LTC_OFS_MODE 8'h09
`define LTC_OFS_CFG 8'h0A
`define LTC_OFS_RED_AMP 8'h0C
`define LTC_OFS_IR_AMP 8'h0D
`define LTC_OFS_SLOT_LO 8'h11
`define LTC_OFS_SLOT_HI 8'h12
`define LTC_OFS_TEMP_WHOLE 8'h1F
`define LTC_OFS_TEMP_FRAC 8'h20
`define LTC_OFS_TEMP_CFG 8'h21
`define LTC_RST_BYTE 8'h00
`define LTC_SLOT_OFF 3'h0
`define LTC_SLOT_RED 3'h1
`define LTC_SLOT_IR 3'h2
`define LTC_SLOT_NONE_A 3'h3
`define LTC_SLOT_NONE_B 3'h4
`define LTC_MODE_HR 3'h2
`define LTC_MODE_SPO2 3'h3
`define LTC_MODE_MULTI 3'h7
`define LTC_SR_400 3'h3
`define LTC_SR_800 3'h4
`define LTC_SR_1000 3'h5
`define LTC_SR_1600 3'h6
`define LTC_SR_3200 3'h7
`define LTC_RES_BASE 5'h0F
`define LTC_SLOT_LAST 2'h3
`define LTC_I2C_BITS 4'h8
`endif

// File: verilog/ltc_pkg.sv
// Purpose: shared types of the led slot and die temperature block
// Assumes: nothing beyond the map header
// Notes: states carry no explicit codes
package ltc_pkg;
	typedef logic [2:0] ltc_slot_sel_type;
	typedef enum logic [3:0] {I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_PTR, I2C_PACK,
		I2C_WDATA, I2C_WACK, I2C_RDATA, I2C_RACK} ltc_i2c_state_type;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_WAIT, SEQ_PUSH} ltc_seq_state_type;
endpackage : ltc_pkg

// File: verilog/ltc_rate_clamp.sv
// Purpose: limits a requested sample rate code to what the pulse width allows
// Assumes: codes as in the map header
// Notes: purely combinational
`include "ltc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ltc_rate_clamp import ltc_pkg::*; (
	input wire logic [2:0] mode,
	input wire logic [1:0] pw,
	input wire logic [2:0] sr_req,
	output logic [2:0] sr_ok
);
	wire logic hr_mode;
	wire logic [2:0] max_hr;
	wire logic [2:0] max_two;
	wire logic [2:0] max_sel;
	assign hr_mode = (mode == `LTC_MODE_HR);
	// heart-rate limits per pulse width
	assign max_hr = (pw == 2'h0) ? `LTC_SR_3200 :
		(pw == 2'h3) ? `LTC_SR_1000 : `LTC_SR_1600;
	// two-led limits, 3200 never allowed
	assign max_two = (pw == 2'h0) ? `LTC_SR_1600 : (pw == 2'h1) ? `LTC_SR_1000 :
		(pw == 2'h2) ? `LTC_SR_800 : `LTC_SR_400;
	assign max_sel = hr_mode ? max_hr : max_two;
	// too high a request stores the highest allowed code
	assign sr_ok = (sr_req > max_sel) ? max_sel : sr_req;
endmodule : ltc_rate_clamp
`default_nettype wire

// File: verilog/ltc_skid_buf.sv
// Purpose: two-entry buffer so a stalled receiver loses no slot word
// Assumes: one clock, synchronous active-low reset
// Notes: output word and valid come straight from flops
`timescale 1ns/1ps
`default_nettype none
module ltc_skid_buf import ltc_pkg::*; #(parameter int WIDTH = 24) (
	input wire logic clk,
	input wire logic rst_n,
	ltc_stream_if.sink in_s,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] head_r;
	logic [WIDTH-1:0] tail_r;
	logic head_v_r;
	logic tail_v_r;
	wire logic push;
	wire logic pop;
	// ready drops only when both entries are held, which stalls the sequencer
	assign in_s.ready = ~tail_v_r;
	assign push = in_s.valid & ~tail_v_r;
	assign pop = head_v_r & out_ready;
	assign out_valid = head_v_r;
	assign out_data = head_r;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			head_v_r <= 1'b0;
			tail_v_r <= 1'b0;
			head_r <= '0;
			tail_r <= '0;
		end else if (pop) begin
			head_v_r <= tail_v_r | push;
			if (tail_v_r) head_r <= tail_r;
			else if (push) head_r <= in_s.data;
			tail_v_r <= 1'b0;
		end else if (push) begin
			if (!head_v_r) begin
				head_r <= in_s.data;
				head_v_r <= 1'b1;
			end else begin
				tail_r <= in_s.data;
				tail_v_r <= 1'b1;
			end
		end
	end
	AST_BUF_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		head_v_r && !out_ready |=> head_v_r && $stable(head_r))
		else $error("buffered word changed while stalled");
endmodule : ltc_skid_buf
`default_nettype wire

// File: verilog/ltc_stream_if.sv
// Purpose: valid/ready word stream between the sequencer and the buffer
// Assumes: one clock
// Notes: source drives valid and data, sink drives ready
`timescale 1ns/1ps
`default_nettype none
interface ltc_stream_if;
	logic valid;
	logic ready;
	logic [23:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : ltc_stream_if
`default_nettype wire

// File: verilog/ltc_top.sv
// Purpose: led slot sequencing, drive codes and die temperature readout
// Assumes: register access over a serial two-wire port, analog side on clk
// Notes: sda is open drain, driven only low
// Summary of operation
// - red and infrared drive codes, reset zero
// - drive code passed linearly to led driver
// - up to four slots, two selectors per register
// - selector decodes off, red, infrared or dark
// - each active slot pushes one three-byte word
// - whole degrees read-only, two's complement, reset zero
// - four-bit sixteenths field, read-only
// - fraction is unsigned offset on signed whole
// - writing start bit runs one conversion
// - start bit self-clears at conversion end
// - resolution follows pulse width, 15 to 18
// - two-led rate limits per pulse width
// - heart-rate limits per pulse width
// - disallowed rate stored as highest allowed
// - two-bit pulse width shared by both leds
// - selectors act in multi-led mode only
`include "ltc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ltc_top import ltc_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary bus address
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic sample_tick,
	input wire logic slot_conv_done,
	input wire logic [17:0] slot_result,
	input wire logic temp_conv_done,
	input wire logic [7:0] temp_whole_in,
	input wire logic [3:0] temp_frac_in,
	input wire logic fifo_ready,
	output logic fifo_valid,
	output logic [23:0] fifo_word,
	output logic led_red_on,
	output logic led_ir_on,
	output logic [7:0] led_drive_code,
	output logic slot_conv_start,
	output logic temp_conv_start,
	output logic [1:0] pulse_width_sel,
	output logic [2:0] sample_rate_sel,
	output logic [4:0] adc_res_bits,
	output logic [2:0] mode_sel
);
	logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
	ltc_i2c_state_type ist_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r, ptr_r, wr_addr_r, wr_data_r;
	logic rw_r, oe_r, wr_stb_r, mack_r;
	logic [7:0] red_drive_code_r, ir_drive_code_r, temp_whole_degrees_r;
	logic [3:0] temp_sixteenths_r;
	ltc_slot_sel_type time_slot_one_sel_r, time_slot_two_sel_r;
	ltc_slot_sel_type time_slot_three_sel_r, time_slot_four_sel_r;
	logic [2:0] mode_r, sample_rate_sel_r;
	logic [1:0] pulse_width_sel_r, range_r;
	logic temp_start_r, temp_req_r;
	logic [4:0] res_r;
	ltc_seq_state_type seq_r;
	logic [1:0] slot_r;
	logic red_r, ir_r, conv_r, push_v_r;
	logic [7:0] code_r;
	logic [23:0] word_r;
	ltc_stream_if word_s ();

	// pins pass two flops before anything looks at them
	always_ff @(posedge clk) begin
		scl_m_r <= scl_in;
		scl_s_r <= scl_m_r;
		scl_d_r <= scl_s_r;
		sda_m_r <= sda_in;
		sda_s_r <= sda_m_r;
		sda_d_r <= sda_s_r;
	end
	wire logic scl_rise = scl_s_r & ~scl_d_r;
	wire logic scl_fall = ~scl_s_r & scl_d_r;
	wire logic bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	wire logic bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
	wire logic byte_done = (bit_r == `LTC_I2C_BITS);
	wire logic [7:0] ptr_inc = ptr_r + 8'h01;
	wire logic [7:0] rd_data =
		(ptr_r == `LTC_OFS_MODE) ? {5'h00, mode_r} :
		(ptr_r == `LTC_OFS_CFG) ? {1'b0, range_r, sample_rate_sel_r, pulse_width_sel_r} :
		(ptr_r == `LTC_OFS_RED_AMP) ? red_drive_code_r :
		(ptr_r == `LTC_OFS_IR_AMP) ? ir_drive_code_r :
		(ptr_r == `LTC_OFS_SLOT_LO) ? {1'b0, time_slot_two_sel_r, 1'b0, time_slot_one_sel_r} :
		(ptr_r == `LTC_OFS_SLOT_HI) ? {1'b0, time_slot_four_sel_r, 1'b0, time_slot_three_sel_r} :
		(ptr_r == `LTC_OFS_TEMP_WHOLE) ? temp_whole_degrees_r :
		(ptr_r == `LTC_OFS_TEMP_FRAC) ? {4'h0, temp_sixteenths_r} :
		(ptr_r == `LTC_OFS_TEMP_CFG) ? {7'h00, temp_start_r} : `LTC_RST_BYTE;

	// serial register port: 7-bit address, pointer byte, auto-increment
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ist_r <= I2C_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			ptr_r <= 8'h00;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
			rw_r <= 1'b0;
			oe_r <= 1'b0;
			wr_stb_r <= 1'b0;
			mack_r <= 1'b0;
		end else begin
			wr_stb_r <= 1'b0;
			if (bus_start) begin
				ist_r <= I2C_ADDR;
				bit_r <= 4'h0;
				oe_r <= 1'b0;
			end else if (bus_stop) begin
				ist_r <= I2C_IDLE;
				oe_r <= 1'b0;
			end else if (scl_rise) begin
				case (ist_r)
					I2C_ADDR, I2C_PTR, I2C_WDATA: begin
						sh_r <= {sh_r[6:0], sda_s_r};
						bit_r <= bit_r + 4'h1;
					end
					I2C_RDATA: bit_r <= bit_r + 4'h1;
					I2C_RACK: mack_r <= ~sda_s_r;
					default: ;
				endcase
			end else if (scl_fall) begin
				case (ist_r)
					I2C_ADDR: if (byte_done) begin
						if (sh_r[7:1] == DEV_ADDR) begin
							ist_r <= I2C_AACK;
							oe_r <= 1'b1;
							rw_r <= sh_r[0];
						end else ist_r <= I2C_IDLE;
					end
					I2C_AACK: begin
						bit_r <= 4'h0;
						if (rw_r) begin
							ist_r <= I2C_RDATA;
							sh_r <= rd_data;
							oe_r <= ~rd_data[7];
							ptr_r <= ptr_inc;
						end else begin
							ist_r <= I2C_PTR;
							oe_r <= 1'b0;
						end
					end
					I2C_PTR: if (byte_done) begin
						ptr_r <= sh_r;
						ist_r <= I2C_PACK;
						oe_r <= 1'b1;
					end
					I2C_PACK, I2C_WACK: begin
						bit_r <= 4'h0;
						oe_r <= 1'b0;
						ist_r <= I2C_WDATA;
					end
					I2C_WDATA: if (byte_done) begin
						wr_stb_r <= 1'b1;
						wr_addr_r <= ptr_r;
						wr_data_r <= sh_r;
						ptr_r <= ptr_inc;
						ist_r <= I2C_WACK;
						oe_r <= 1'b1;
					end
					I2C_RDATA: if (byte_done) begin
						oe_r <= 1'b0;
						ist_r <= I2C_RACK;
					end else begin
						sh_r <= {sh_r[6:0], 1'b0};
						oe_r <= ~sh_r[6];
					end
					I2C_RACK: if (mack_r) begin
						bit_r <= 4'h0;
						sh_r <= rd_data;
						oe_r <= ~rd_data[7];
						ptr_r <= ptr_inc;
						ist_r <= I2C_RDATA;
					end else ist_r <= I2C_IDLE;
					default: ist_r <= I2C_IDLE;
				endcase
			end
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe = oe_r;

	wire logic wr_mode = wr_stb_r && (wr_addr_r == `LTC_OFS_MODE);
	wire logic wr_cfg = wr_stb_r && (wr_addr_r == `LTC_OFS_CFG);
	wire logic wr_red = wr_stb_r && (wr_addr_r == `LTC_OFS_RED_AMP);
	wire logic wr_ir = wr_stb_r && (wr_addr_r == `LTC_OFS_IR_AMP);
	wire logic wr_lo = wr_stb_r && (wr_addr_r == `LTC_OFS_SLOT_LO);
	wire logic wr_hi = wr_stb_r && (wr_addr_r == `LTC_OFS_SLOT_HI);
	wire logic wr_go = wr_stb_r && (wr_addr_r == `LTC_OFS_TEMP_CFG) && wr_data_r[0];
	wire logic [2:0] sr_clamped;
	ltc_rate_clamp u_clamp (
		.mode(mode_r),
		.pw(wr_data_r[1:0]),
		.sr_req(wr_data_r[4:2]),
		.sr_ok(sr_clamped)
	);

	// configuration registers; writes to read-only offsets are dropped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			red_drive_code_r <= `LTC_RST_BYTE;
			ir_drive_code_r <= `LTC_RST_BYTE;
			{time_slot_two_sel_r, time_slot_one_sel_r} <= 6'h00;
			{time_slot_four_sel_r, time_slot_three_sel_r} <= 6'h00;
			mode_r <= 3'h0;
			{range_r, sample_rate_sel_r, pulse_width_sel_r} <= 7'h00;
		end else begin
			if (wr_red) red_drive_code_r <= wr_data_r;
			if (wr_ir) ir_drive_code_r <= wr_data_r;
			if (wr_lo) {time_slot_two_sel_r, time_slot_one_sel_r} <=
				{wr_data_r[6:4], wr_data_r[2:0]};
			if (wr_hi) {time_slot_four_sel_r, time_slot_three_sel_r} <=
				{wr_data_r[6:4], wr_data_r[2:0]};
			if (wr_mode) mode_r <= wr_data_r[2:0];
			if (wr_cfg) {range_r, sample_rate_sel_r, pulse_width_sel_r} <=
				{wr_data_r[6:5], sr_clamped, wr_data_r[1:0]};
		end
	end

	// start is set by a host write, cleared only by the end of conversion;
	// a write in the finishing cycle starts the next conversion
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			temp_start_r <= 1'b0;
			temp_req_r <= 1'b0;
			temp_whole_degrees_r <= `LTC_RST_BYTE;
			temp_sixteenths_r <= 4'h0;
		end else begin
			temp_req_r <= wr_go && (!temp_start_r || temp_conv_done);
			temp_start_r <= wr_go || (temp_start_r && !temp_conv_done);
			if (temp_start_r && temp_conv_done) begin
				temp_whole_degrees_r <= temp_whole_in;
				temp_sixteenths_r <= temp_frac_in;
			end
		end
	end
	assign temp_conv_start = temp_req_r;

	// effective selectors: fixed patterns in the heart-rate and SpO2 modes
	wire logic multi = (mode_r == `LTC_MODE_MULTI);
	wire logic [2:0] eff_one = multi ? time_slot_one_sel_r :
		((mode_r == `LTC_MODE_HR) || (mode_r == `LTC_MODE_SPO2)) ? `LTC_SLOT_RED : `LTC_SLOT_OFF;
	wire logic [2:0] eff_two = multi ? time_slot_two_sel_r :
		(mode_r == `LTC_MODE_SPO2) ? `LTC_SLOT_IR : `LTC_SLOT_OFF;
	wire logic [2:0] eff_three = multi ? time_slot_three_sel_r : `LTC_SLOT_OFF;
	wire logic [2:0] eff_four = multi ? time_slot_four_sel_r : `LTC_SLOT_OFF;
	wire logic [2:0] cur_sel = (slot_r == 2'h0) ? eff_one : (slot_r == 2'h1) ? eff_two :
		(slot_r == 2'h2) ? eff_three : eff_four;
	// reserved codes fall outside this set and are skipped like off
	wire logic cur_active = (cur_sel == `LTC_SLOT_RED) || (cur_sel == `LTC_SLOT_IR) ||
		(cur_sel == `LTC_SLOT_NONE_A) || (cur_sel == `LTC_SLOT_NONE_B);
	wire logic last_slot = (slot_r == `LTC_SLOT_LAST);

	// slot walk; a full buffer holds the walk in SEQ_PUSH, so no word is lost
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seq_r <= SEQ_IDLE;
			slot_r <= 2'h0;
			red_r <= 1'b0;
			ir_r <= 1'b0;
			conv_r <= 1'b0;
			push_v_r <= 1'b0;
			code_r <= 8'h00;
			word_r <= 24'h000000;
		end else begin
			conv_r <= 1'b0;
			case (seq_r)
				SEQ_IDLE: if (sample_tick) begin
					slot_r <= 2'h0;
					seq_r <= SEQ_SCAN;
				end
				SEQ_SCAN: if (cur_active) begin
					red_r <= (cur_sel == `LTC_SLOT_RED);
					ir_r <= (cur_sel == `LTC_SLOT_IR);
					code_r <= (cur_sel == `LTC_SLOT_RED) ? red_drive_code_r :
						(cur_sel == `LTC_SLOT_IR) ? ir_drive_code_r : 8'h00;
					conv_r <= 1'b1;
					seq_r <= SEQ_WAIT;
				end else if (last_slot) seq_r <= SEQ_IDLE;
				else slot_r <= slot_r + 2'h1;
				SEQ_WAIT: if (slot_conv_done) begin
					red_r <= 1'b0;
					ir_r <= 1'b0;
					code_r <= 8'h00;
					word_r <= {6'h00, slot_result};
					push_v_r <= 1'b1;
					seq_r <= SEQ_PUSH;
				end
				SEQ_PUSH: if (word_s.ready) begin
					push_v_r <= 1'b0;
					if (last_slot) seq_r <= SEQ_IDLE;
					else begin
						slot_r <= slot_r + 2'h1;
						seq_r <= SEQ_SCAN;
					end
				end
				default: seq_r <= SEQ_IDLE;
			endcase
		end
	end
	assign word_s.valid = push_v_r;
	assign word_s.data = word_r;
	ltc_skid_buf #(.WIDTH(24)) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_s(word_s),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_word)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) res_r <= `LTC_RES_BASE;
		else res_r <= `LTC_RES_BASE + {3'h0, pulse_width_sel_r};
	end
	assign adc_res_bits = res_r;
	assign led_red_on = red_r;
	assign led_ir_on = ir_r;
	assign led_drive_code = code_r;
	assign slot_conv_start = conv_r;
	assign pulse_width_sel = pulse_width_sel_r;
	assign sample_rate_sel = sample_rate_sel_r;
	assign mode_sel = mode_r;

	AST_TEMP_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		temp_start_r && temp_conv_done && !wr_go |=> !temp_start_r)
		else $error("start bit did not self-clear");
	AST_TEMP_RESULT: assert property (@(posedge clk) disable iff (!rst_n)
		temp_start_r && temp_conv_done |=> temp_whole_degrees_r == $past(temp_whole_in)
		&& temp_sixteenths_r == $past(temp_frac_in))
		else $error("result not captured with start clear");
	AST_TEMP_ONCE: assert property (@(posedge clk) disable iff (!rst_n)
		temp_req_r |-> temp_start_r ##1 !temp_req_r)
		else $error("conversion request not single");
	AST_RATE_HR: assert property (@(posedge clk) disable iff (!rst_n)
		wr_cfg && mode_r == `LTC_MODE_HR && wr_data_r[1:0] == 2'h3
		|=> sample_rate_sel_r <= `LTC_SR_1000)
		else $error("heart-rate limit exceeded");
	AST_RATE_TWO: assert property (@(posedge clk) disable iff (!rst_n)
		wr_cfg && mode_r == `LTC_MODE_SPO2 |=> sample_rate_sel_r != `LTC_SR_3200)
		else $error("3200 stored in two-led mode");
	AST_SLOT_LED: assert property (@(posedge clk) disable iff (!rst_n)
		seq_r == SEQ_SCAN && cur_sel > `LTC_SLOT_NONE_B |=> !red_r && !ir_r && !conv_r)
		else $error("reserved slot fired");
	AST_SLOT_RED: assert property (@(posedge clk) disable iff (!rst_n)
		seq_r == SEQ_SCAN && cur_sel == `LTC_SLOT_RED
		|=> red_r && !ir_r && code_r == red_drive_code_r)
		else $error("red slot drove wrong led");
	AST_PUSH_AFTER: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(push_v_r) |-> $past(slot_conv_done) && word_s.data[17:0] == $past(slot_result))
		else $error("word pushed without conversion");
	AST_MULTI_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
		seq_r == SEQ_SCAN && !multi && slot_r > 2'h1 |=> !conv_r)
		else $error("upper slot fired outside multi mode");
	AST_RES: assert property (@(posedge clk) disable iff (!rst_n)
		pulse_width_sel_r == 2'h3 ##1 pulse_width_sel_r == 2'h3 |-> adc_res_bits == 5'h12)
		else $error("resolution mismatch");
endmodule : ltc_top
`default_nettype wire
